// ### rtl/serial_debug_control_regs.sv
// Operation
// - enable_background_entry clear refuses halt entry; non-intrusive commands still work.
// - enable_background_entry stays set once written; only normal reset clears it.
// - background_active reads 1 in debug halt, 0 while user code runs.
// - breakpoint_enable clear disables breakpoint, ignores force select and match address.
// - force select set: address match halts at next instruction boundary.
// - force select clear: match tags opcode; halt when it reaches queue end.
// - link_clock_select resets 0 (alternate clock); 1 selects bus clock.
// - halted_status reads 1 in wait/stop or halt entered from wait/stop.
// - halt command accepted in wait/stop, moving cpu into debug halt.
// - halt_access_failure set when memory access fails against wait/stop entry.
// - slow_access_failure never reported; no slow memory exists.
// - status/control reachable only by serial status-read and control-write.
// - breakpoint address is 16 bits, only via serial breakpoint commands.
// - serial memory write of 1 to force-reset bit 0 resets the device.
// - user writes to force-reset ignored; reads always return 0x00.
// - trace unit register space sits in normal memory, user accessible.
// - comparator A high resets 0x00, always readable, write blocked when armed.
// - enable_background_entry writes blocked while in debug halt.
// - control-write never changes the four status flags.
// - breakpoint with entry disabled executes software interrupt instead.
`default_nettype none
module serial_debug_control_regs
    import dbg_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // decoded serial debug command port
    input  wire logic        ser_cmd_valid,
    input  wire logic [2:0]  ser_cmd,
    input  wire logic [15:0] ser_addr,
    input  wire logic [15:0] ser_wdata,
    output var  logic [15:0] ser_rdata,
    output var  logic        ser_rvalid,
    // cpu user bus to the high register page
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output var  logic [7:0]  cpu_rdata,
    output var  logic        cpu_rvalid,
    // cpu status and pipeline
    input  wire logic        cpu_addr_valid,
    input  wire logic        opcode_fetch,
    input  wire logic        queue_end_tagged,
    input  wire logic        instr_boundary,
    input  wire logic        cpu_in_wait_stop,
    input  wire logic        cpu_resume,
    input  wire logic        bg_instr,
    input  wire logic        halt_cmd,
    input  wire logic        mem_access_failed,
    input  wire logic        trace_armed,
    // outputs
    output var  logic        halt_request,
    output var  logic        swi_request,
    output var  logic        tag_opcode,
    output var  logic        link_clock_select,
    output var  logic        force_reset
);
    ////////////////////////////////////////////////////////////////////////////
    run_state_e  state_q;
    logic        enable_bg_q;
    logic        bkpt_en_q;
    logic        force_sel_q;
    logic        clk_sel_q;
    logic        from_wait_q;
    logic        halt_fail_q;
    logic [15:0] bkpt_addr_q;
    logic [7:0]  cmp_a_high_q;
    logic        rst_trig;
    logic        rst_pulse;
    logic        ser_wctrl;
    logic        halt_entry;
    logic        bkpt_event;
    logic        force_pend_q;
    logic        bg_active;
    logic        halted;
    logic [7:0]  status_byte;
    cpu_side_if  cpu_if ();

    function automatic logic is_cmd(input logic [2:0] c, input serial_cmd_e want);
        return ser_cmd_valid && (c == want);
    endfunction

    assign ser_wctrl  = is_cmd(ser_cmd, CMD_WR_CTRL);
    assign bg_active  = (state_q == RUN_HALT);
    assign halted     = (state_q == RUN_WAIT) || (bg_active && from_wait_q);
    // force hit waits for a boundary; a tag hit already sits at queue end
    assign bkpt_event = force_sel_q ? (cpu_if.bkpt_hit || force_pend_q) && instr_boundary
                                    : cpu_if.bkpt_hit;
    // halt entry sources; all need permission
    assign halt_entry = enable_bg_q && state_q != RUN_HALT
                        && (halt_cmd || bg_instr || bkpt_event);
    assign status_byte = {enable_bg_q, bg_active, bkpt_en_q, force_sel_q, clk_sel_q,
                          halted, halt_fail_q, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    bkpt_match u_bkpt (
        .sys_clk          (sys_clk),
        .resetn           (resetn),
        .enable           (bkpt_en_q),
        .force_sel        (force_sel_q),
        .match_addr       (bkpt_addr_q),
        .cpu_addr         (cpu_addr),
        .cpu_addr_valid   (cpu_addr_valid),
        .opcode_fetch     (opcode_fetch),
        .queue_end_tagged (queue_end_tagged),
        .cpu              (cpu_if.bkpt)
    );

    assign rst_trig = is_cmd(ser_cmd, CMD_WR_BYTE) && ser_addr == ADDR_FORCE_RESET
                      && ser_wdata[BIT_FORCE_RESET];

    force_reset_gen u_rst (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .trigger   (rst_trig),
        .reset_out (rst_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // run state tracking
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= RUN_USER;
        end else begin
            case (state_q)
                RUN_USER: begin
                    if (halt_entry) begin
                        state_q <= RUN_HALT;
                    end else if (cpu_in_wait_stop) begin
                        state_q <= RUN_WAIT;
                    end
                end
                RUN_WAIT: begin
                    if (halt_entry) begin
                        state_q <= RUN_HALT;
                    end else if (!cpu_in_wait_stop) begin
                        state_q <= RUN_USER;
                    end
                end
                RUN_HALT: begin
                    if (cpu_resume) begin
                        state_q <= RUN_USER;
                    end
                end
                default: state_q <= RUN_USER;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            from_wait_q <= 1'b0;
        end else if (halt_entry) begin
            from_wait_q <= (state_q == RUN_WAIT);
        end else if (cpu_resume) begin
            from_wait_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits; status flags are not writable here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            enable_bg_q <= CTRL_RESET[BIT_ENABLE_BG];
            bkpt_en_q   <= CTRL_RESET[BIT_BKPT_ENABLE];
            force_sel_q <= CTRL_RESET[BIT_FORCE_TAG];
            clk_sel_q   <= CTRL_RESET[BIT_LINK_CLK_SEL];
        end else if (ser_wctrl) begin
            // a halted cpu may not lose its own permission
            if (!bg_active) begin
                // once set, only reset clears the permission
                enable_bg_q <= enable_bg_q || ser_wdata[BIT_ENABLE_BG];
            end
            bkpt_en_q   <= ser_wdata[BIT_BKPT_ENABLE];
            force_sel_q <= ser_wdata[BIT_FORCE_TAG];
            clk_sel_q   <= ser_wdata[BIT_LINK_CLK_SEL];
        end
    end

    // the match hit lasts one cycle; remember it until the next boundary
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            force_pend_q <= 1'b0;
        end else if (instr_boundary || !bkpt_en_q || !force_sel_q) begin
            force_pend_q <= 1'b0;
        end else if (cpu_if.bkpt_hit) begin
            force_pend_q <= 1'b1;
        end
    end

    // failure flag: set wins over the clear on resume
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halt_fail_q <= 1'b0;
        end else if (mem_access_failed && cpu_in_wait_stop) begin
            halt_fail_q <= 1'b1;
        end else if (cpu_resume) begin
            halt_fail_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bkpt_addr_q <= BKPT_RESET;
        end else if (is_cmd(ser_cmd, CMD_WR_BKPT)) begin
            bkpt_addr_q <= ser_wdata;
        end
    end

    // user-visible trace comparator byte
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_a_high_q <= CMP_A_HIGH_RESET;
        end else if (cpu_wr && cpu_addr == ADDR_CMP_A_HIGH && !trace_armed) begin
            cmp_a_high_q <= cpu_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read paths
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ser_rdata  <= 16'h0000;
            ser_rvalid <= 1'b0;
        end else begin
            ser_rvalid <= is_cmd(ser_cmd, CMD_RD_STATUS) || is_cmd(ser_cmd, CMD_RD_BKPT)
                          || is_cmd(ser_cmd, CMD_RD_BYTE);
            if (is_cmd(ser_cmd, CMD_RD_STATUS)) begin
                ser_rdata <= {8'h00, status_byte};
            end else if (is_cmd(ser_cmd, CMD_RD_BKPT)) begin
                ser_rdata <= bkpt_addr_q;
            end else if (is_cmd(ser_cmd, CMD_RD_BYTE) && ser_addr == ADDR_CMP_A_HIGH) begin
                ser_rdata <= {8'h00, cmp_a_high_q};
            end else begin
                ser_rdata <= {8'h00, FORCE_RESET_READ};
            end
        end
    end

    // user bus never reaches debug status or force reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata  <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_rd;
            if (cpu_rd && cpu_addr == ADDR_CMP_A_HIGH) begin
                cpu_rdata <= cmp_a_high_q;
            end else begin
                cpu_rdata <= FORCE_RESET_READ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu requests
    assign cpu_if.halt_req = halt_request;
    assign cpu_if.swi_req  = swi_request;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halt_request <= 1'b0;
            swi_request  <= 1'b0;
            tag_opcode   <= 1'b0;
        end else begin
            halt_request <= halt_entry;
            // without permission the break turns into a software interrupt
            swi_request  <= bkpt_event && !enable_bg_q;
            tag_opcode   <= cpu_if.tag_mark;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            link_clock_select <= 1'b0;
            force_reset       <= 1'b0;
        end else begin
            link_clock_select <= clk_sel_q;
            force_reset       <= rst_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_ctrl_write_blocked;
        ser_wctrl && bg_active;
    endsequence

    chk_entry_needs_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
        !enable_bg_q |-> ##1 !halt_request)
        else $error("halt requested without permission");
    chk_enable_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        enable_bg_q |=> enable_bg_q)
        else $error("enable bit dropped without write");
    chk_bg_active_state: assert property (@(posedge sys_clk) disable iff (!resetn)
        halt_entry |=> status_byte[BIT_BG_ACTIVE])
        else $error("background active not shown after entry");
    chk_bkpt_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
        !bkpt_en_q && !$past(bkpt_en_q) |-> !cpu_if.bkpt_hit)
        else $error("breakpoint hit while disabled");
    chk_halted_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_q == RUN_WAIT |-> status_byte[BIT_HALTED])
        else $error("halted status missing in wait");
    chk_wait_to_halt: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_q == RUN_WAIT && halt_cmd && enable_bg_q |=> bg_active && halted)
        else $error("halt from wait not taken");
    chk_slow_fail_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        ser_rvalid && $past(is_cmd(ser_cmd, CMD_RD_STATUS)) |-> !ser_rdata[BIT_SLOW_FAIL])
        else $error("slow access failure reported");
    chk_enable_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_ctrl_write_blocked |=> enable_bg_q == $past(enable_bg_q))
        else $error("enable bit written while halted");
    chk_force_reset_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        rst_trig |-> ##2 force_reset)
        else $error("force reset not produced");
    chk_swi_no_perm: assert property (@(posedge sys_clk) disable iff (!resetn)
        bkpt_event && !enable_bg_q |=> swi_request && !halt_request)
        else $error("software interrupt missing");
endmodule
`default_nettype wire

// ### rtl/dbg_ctrl_pkg.sv
`default_nettype none
package dbg_ctrl_pkg;
    // serial command codes seen on the decoded command port
    typedef enum logic [2:0] {
        CMD_NONE      = 3'b000,
        CMD_RD_STATUS = 3'b001,
        CMD_WR_CTRL   = 3'b010,
        CMD_RD_BKPT   = 3'b011,
        CMD_WR_BKPT   = 3'b100,
        CMD_WR_BYTE   = 3'b101,
        CMD_RD_BYTE   = 3'b110
    } serial_cmd_e;

    // cpu run state
    typedef enum logic [1:0] {
        RUN_USER = 2'b00,
        RUN_WAIT = 2'b01,
        RUN_HALT = 2'b10
    } run_state_e;

    localparam int unsigned BIT_ENABLE_BG    = 7;
    localparam int unsigned BIT_BG_ACTIVE    = 6;
    localparam int unsigned BIT_BKPT_ENABLE  = 5;
    localparam int unsigned BIT_FORCE_TAG    = 4;
    localparam int unsigned BIT_LINK_CLK_SEL = 3;
    localparam int unsigned BIT_HALTED       = 2;
    localparam int unsigned BIT_HALT_FAIL    = 1;
    localparam int unsigned BIT_SLOW_FAIL    = 0;
    localparam int unsigned BIT_FORCE_RESET  = 0;

    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [15:0] BKPT_RESET       = 16'h0000;
    localparam logic [7:0]  CMP_A_HIGH_RESET = 8'h00;
    localparam logic [7:0]  FORCE_RESET_READ = 8'h00;

    // high-page byte addresses; placement is ours
    localparam logic [15:0] ADDR_FORCE_RESET = 16'h1800;
    localparam logic [15:0] ADDR_CMP_A_HIGH  = 16'h1810;

    // reset pulse width requested from the reset controller
    localparam int unsigned RESET_PULSE_CYC  = 4;
endpackage
`default_nettype wire

// ### rtl/cpu_side_if.sv
`default_nettype none
interface cpu_side_if;
    logic        halt_req;
    logic        swi_req;
    logic        bkpt_hit;
    logic        tag_mark;
    modport ctrl (output halt_req, output swi_req, input bkpt_hit, input tag_mark);
    modport bkpt (input halt_req, input swi_req, output bkpt_hit, output tag_mark);
endinterface
`default_nettype wire

// ### rtl/bkpt_match.sv
`default_nettype none
module bkpt_match
    import dbg_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        enable,
    input  wire logic        force_sel,
    input  wire logic [15:0] match_addr,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_addr_valid,
    input  wire logic        opcode_fetch,
    input  wire logic        queue_end_tagged,
    cpu_side_if.bkpt         cpu
);
    logic hit_q;
    logic tag_q;
    logic match;

    assign match = enable && cpu_addr_valid && (cpu_addr == match_addr);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hit_q <= 1'b0;
            tag_q <= 1'b0;
        end else begin
            // force: any bus match, opcode or not
            hit_q <= (match && force_sel) || (enable && !force_sel && queue_end_tagged);
            tag_q <= match && !force_sel && opcode_fetch;
        end
    end

    assign cpu.bkpt_hit = hit_q;
    assign cpu.tag_mark = tag_q;
endmodule
`default_nettype wire

// ### rtl/force_reset_gen.sv
`default_nettype none
module force_reset_gen
    import dbg_ctrl_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic trigger,
    output var  logic reset_out
);
    logic [2:0] cnt_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 3'h0;
        end else if (trigger) begin
            cnt_q <= 3'(RESET_PULSE_CYC);
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_out <= 1'b0;
        end else begin
            reset_out <= trigger || (cnt_q > 3'h1);
        end
    end
endmodule
`default_nettype wire

// ### verif/debug_host_model.sv
`default_nettype none
module debug_host_model
    import dbg_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    output var  logic        ser_cmd_valid,
    output var  logic [2:0]  ser_cmd,
    output var  logic [15:0] ser_addr,
    output var  logic [15:0] ser_wdata,
    output var  logic        halt_cmd,
    input  wire logic [15:0] ser_rdata,
    input  wire logic        ser_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_cmd_valid = 1'b0;
        ser_cmd       = CMD_NONE;
        ser_addr      = 16'h0000;
        ser_wdata     = 16'h0000;
        halt_cmd      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one command per call; a read waits a bounded time for its answer
    task automatic send(input logic [2:0] cmd, input logic [15:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        @(posedge sys_clk);
        ser_cmd_valid <= 1'b1;
        ser_cmd       <= cmd;
        ser_addr      <= addr;
        ser_wdata     <= wdata;
        @(posedge sys_clk);
        ser_cmd_valid <= 1'b0;
        ser_cmd       <= CMD_NONE;
        // released lines invert so stale values never look valid
        ser_addr      <= ~addr;
        ser_wdata     <= ~wdata;
        #1;
        rdata = 16'hXXXX;
        if (cmd == CMD_RD_STATUS || cmd == CMD_RD_BKPT || cmd == CMD_RD_BYTE) begin
            for (n = 0; n < 4 && ser_rvalid !== 1'b1; n++) begin
                @(posedge sys_clk);
                #1;
            end
            if (ser_rvalid === 1'b1) begin
                rdata = ser_rdata;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // halt, then confirm the status before anything else
    task automatic force_halt(output logic [15:0] status);
        @(posedge sys_clk);
        halt_cmd <= 1'b1;
        @(posedge sys_clk);
        halt_cmd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        send(CMD_RD_STATUS, 16'h0000, 16'h0000, status);
    endtask
endmodule
`default_nettype wire

// ### verif/serial_debug_control_regs_tb.sv
`default_nettype none
module serial_debug_control_regs_tb
    import dbg_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, resetn, ser_cmd_valid, ser_rvalid, halt_cmd;
    logic [2:0]  ser_cmd;
    logic [15:0] ser_addr, ser_wdata, ser_rdata, cpu_addr, rd;
    logic        cpu_wr, cpu_rd, cpu_rvalid, cpu_in_wait_stop, trace_armed;
    logic [7:0]  cpu_wdata, cpu_rdata, crd;
    logic [6:0]  pls;
    logic        halt_request, swi_request, tag_opcode, link_clock_select, force_reset;
    int          err_total, n_compared, n_halt, n_swi, n_tag, n_frst;

    localparam logic [6:0] AV = 7'h01, OF = 7'h02, QE = 7'h04, IB = 7'h08;
    localparam logic [6:0] RS = 7'h10, BG = 7'h20, MF = 7'h40;

    debug_host_model host (.sys_clk(sys_clk), .ser_cmd_valid(ser_cmd_valid),
        .ser_cmd(ser_cmd), .ser_addr(ser_addr), .ser_wdata(ser_wdata),
        .halt_cmd(halt_cmd), .ser_rdata(ser_rdata), .ser_rvalid(ser_rvalid));

    serial_debug_control_regs dut (.sys_clk(sys_clk), .resetn(resetn),
        .ser_cmd_valid(ser_cmd_valid), .ser_cmd(ser_cmd), .ser_addr(ser_addr),
        .ser_wdata(ser_wdata), .ser_rdata(ser_rdata), .ser_rvalid(ser_rvalid),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_addr_valid(pls[0]),
        .opcode_fetch(pls[1]), .queue_end_tagged(pls[2]), .instr_boundary(pls[3]),
        .cpu_in_wait_stop(cpu_in_wait_stop), .cpu_resume(pls[4]), .bg_instr(pls[5]),
        .halt_cmd(halt_cmd), .mem_access_failed(pls[6]), .trace_armed(trace_armed),
        .halt_request(halt_request), .swi_request(swi_request), .tag_opcode(tag_opcode),
        .link_clock_select(link_clock_select), .force_reset(force_reset));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // pulse outputs counted cycle by cycle, so a stretched pulse shows up
    always @(posedge sys_clk) begin
        if (halt_request === 1'b1) n_halt++;
        if (swi_request === 1'b1) n_swi++;
        if (tag_opcode === 1'b1) n_tag++;
        if (force_reset === 1'b1) n_frst++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic clr();
        n_halt = 0;
        n_swi = 0;
        n_tag = 0;
        n_frst = 0;
    endtask

    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge sys_clk);
        pls <= m;
        @(posedge sys_clk);
        pls <= 7'h00;
    endtask

    task automatic st(input logic [7:0] exp);
        host.send(CMD_RD_STATUS, 16'h0000, 16'h0000, rd);
        check(rd, {8'h00, exp});
    endtask

    task automatic wctl(input logic [7:0] v);
        host.send(CMD_WR_CTRL, 16'h0000, {8'h00, v}, rd);
    endtask

    task automatic cpu_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_wr    <= w;
        cpu_rd    <= !w;
        cpu_addr  <= a;
        cpu_wdata <= d;
        @(posedge sys_clk);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        #1;
        crd = (cpu_rvalid === 1'b1) ? cpu_rdata : 8'hXX;
    endtask

    task automatic do_reset(input int cyc);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, cpu_wr, cpu_rd, cpu_in_wait_stop, trace_armed} = '0;
        {cpu_addr, cpu_wdata, pls} = '0;
        {err_total, n_compared} = '0;
        clr();
        do_reset(6);
        st(8'h00);
        check(16'(link_clock_select), 16'h0000);
        host.send(CMD_RD_BKPT, 16'h0000, 16'h0000, rd);
        check(rd, BKPT_RESET);
        // halt refused while entry is not permitted, reads still answered
        host.force_halt(rd);
        check(rd, 16'h0000);
        pulse(BG);
        settle();
        check(16'(n_halt), 16'h0000);
        $display("test reset_and_refuse done");
        // status flags are not writable
        wctl(8'hFF);
        st(8'hB8);
        check(16'(link_clock_select), 16'h0001);
        wctl(8'h88);
        clr();
        host.force_halt(rd);
        check(rd, 16'h00C8);
        check(16'(n_halt), 16'h0001);
        wctl(8'h00);
        st(8'hC0);
        pulse(RS);
        settle();
        st(8'h80);
        wctl(8'h00);
        st(8'h80);
        $display("test halt_entry done");
        // wait or stop, a failed access, then the recovery sequence
        cpu_in_wait_stop <= 1'b1;
        settle();
        st(8'h84);
        pulse(MF);
        settle();
        st(8'h86);
        host.force_halt(rd);
        cpu_in_wait_stop <= 1'b0;
        check(rd, 16'h00C6);
        settle();
        st(8'hC6);
        host.send(CMD_RD_BKPT, 16'h0000, 16'h0000, rd);
        check(rd, BKPT_RESET);
        pulse(RS);
        settle();
        st(8'h80);
        $display("test wait_stop done");
        // breakpoint in force, tag and disabled modes
        host.send(CMD_WR_BKPT, 16'h0000, 16'hC3A5, rd);
        host.send(CMD_RD_BKPT, 16'h0000, 16'h0000, rd);
        check(rd, 16'hC3A5);
        wctl(8'hB0);
        clr();
        cpu_addr <= 16'hC3A4;
        pulse(AV | IB);
        settle();
        check(16'(n_halt), 16'h0000);
        cpu_addr <= 16'hC3A5;
        pulse(AV);
        pulse(IB);
        settle();
        check(16'(n_halt), 16'h0001);
        pulse(RS);
        wctl(8'hA0);
        clr();
        pulse(AV | OF);
        settle();
        check(16'(n_tag), 16'h0001);
        check(16'(n_halt), 16'h0000);
        pulse(QE);
        settle();
        check(16'(n_halt), 16'h0001);
        pulse(RS);
        wctl(8'h90);
        clr();
        pulse(AV | OF | IB);
        pulse(QE);
        settle();
        check(16'(n_halt + n_tag), 16'h0000);
        $display("test breakpoint done");
        // user bus view of the high page
        cpu_acc(1'b1, ADDR_FORCE_RESET, 8'hFF);
        cpu_acc(1'b0, ADDR_FORCE_RESET, 8'h00);
        check(16'(crd), 16'(FORCE_RESET_READ));
        cpu_acc(1'b1, ADDR_CMP_A_HIGH, 8'h5A);
        cpu_acc(1'b0, ADDR_CMP_A_HIGH, 8'h00);
        check(16'(crd), 16'h005A);
        trace_armed <= 1'b1;
        cpu_acc(1'b1, ADDR_CMP_A_HIGH, 8'hA5);
        cpu_acc(1'b0, ADDR_CMP_A_HIGH, 8'h00);
        check(16'(crd), 16'h005A);
        trace_armed <= 1'b0;
        settle();
        check(16'(n_frst), 16'h0000);
        // serial force reset: upper bits inert, bit 0 fires
        host.send(CMD_WR_BYTE, ADDR_FORCE_RESET, 16'h00FE, rd);
        settle();
        check(16'(n_frst), 16'h0000);
        host.send(CMD_RD_BYTE, ADDR_FORCE_RESET, 16'h0000, rd);
        check(rd, 16'h0000);
        host.send(CMD_WR_BYTE, ADDR_FORCE_RESET, 16'h0001, rd);
        settle();
        settle();
        check(16'(n_frst), 16'(RESET_PULSE_CYC));
        do_reset(2);
        st(8'h00);
        cpu_acc(1'b0, ADDR_CMP_A_HIGH, 8'h00);
        check(16'(crd), 16'(CMP_A_HIGH_RESET));
        $display("test force_reset done");
        // breakpoint without entry permission becomes a software interrupt
        host.send(CMD_WR_BKPT, 16'h0000, 16'hC3A5, rd);
        wctl(8'h30);
        clr();
        cpu_addr <= 16'hC3A5;
        pulse(AV);
        pulse(IB);
        settle();
        check(16'(n_swi), 16'h0001);
        check(16'(n_halt), 16'h0000);
        $display("test swi_fallback done");
        give_verdict();
    end

    // whole run is about two hundred cycles; this is a generous margin
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
